// ===== pkg/eprom_prog_consts.svh
// Offsets, field positions, reset values and timing counts for the EPROM program control
`ifndef EPROM_PROG_CONSTS_SVH
`define EPROM_PROG_CONSTS_SVH
`define EPC_REG_ADDR 16'h001E
`define EPC_RESET 8'h00
`define EPC_LATCH_BIT 1
`define EPC_POWER_BIT 0
`define BOOT_ROM_FIRST 16'h1E00
`define BOOT_ROM_LAST 16'h1FEF
`define EPROM_SIZE 4096
`define EPROM_FIRST 16'h1000
`define CLK_PERIOD_NS 50
`define BOOT_PULSE_US 1000
`define BOOT_PULSE_CYCLES ((`BOOT_PULSE_US * 1000) / `CLK_PERIOD_NS)
`endif

// ===== pkg/eprom_prog_pkg.sv
// Types for the EPROM program control block
package eprom_prog_pkg;
    typedef enum logic [2:0] {
        BOOT_IDLE = 3'b000,
        BOOT_PROG = 3'b001,
        BOOT_WAIT = 3'b010,
        BOOT_VERIFY = 3'b011,
        BOOT_DONE = 3'b100
    } boot_state_t;
endpackage

// ===== verilog/eprom_program_control.sv
// EPROM program control register, programming latch and bootloader sequencer
// How it works
// RULE_01: Boot mode entered at reset release when test-voltage pin and keypad line zero high.
// RULE_02: Bootloader code occupies ROM from 1E00 through 1FEF.
// RULE_03: Bootloader programs each byte for 1 ms, then runs a separate verify pass.
// RULE_04: Control register sits at 001E and resets to zero.
// RULE_05: Latch select 0 gives normal reads; 1 makes EPROM writes capture address and data.
// RULE_06: With latch select set, the array is in programming mode, reads invalid.
// RULE_07: Software should set latch select only with programming voltage present.
// RULE_08: Program power bit 0 removes array power; 1 applies it.
// RULE_09: Program power is forced to 0 whenever latch select is not 1.
// RULE_10: Software sequence: latch, write, power on, wait, power off, unlatch.
// RULE_11: Power off and unlatch are two separate register writes.
// RULE_12: Reserved control bits read zero and ignore writes.
`include "eprom_prog_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module eprom_program_control
    import eprom_prog_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = `BOOT_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // CPU bus
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    // Pins sampled at reset release
    input wire logic i_interrupt_program_voltage_pin_at_test,
    input wire logic i_keypad_line_zero,
    // Bootloader byte source and status
    input wire logic [7:0] i_boot_src_data,
    output logic [11:0] o_boot_src_addr,
    output logic o_boot_mode,
    output logic o_boot_active,
    output logic o_boot_verify_fail,
    output logic o_boot_done,
    // EPROM array side
    output logic o_latch_select,
    output logic o_program_power,
    output logic [11:0] o_prog_addr,
    output logic [7:0] o_prog_data,
    input wire logic [7:0] i_array_rdata
);
    typedef struct packed {
        logic [1:0] vpp_sync;
        logic [1:0] kbi_sync;
        logic started;
        logic boot_mode;
        logic latch_select;
        logic program_power;
        logic [11:0] prog_addr;
        logic [7:0] prog_data;
        logic [7:0] rdata;
        logic rdata_valid;
        boot_state_t bstate;
        logic [11:0] baddr;
        logic [15:0] bcount;
        logic fail;
        logic [1:0] settle;
        logic [15:0] plen;
    } state_t;

    state_t st, next_st;
    logic reg_hit, arr_hit, cpu_wr_ok;

    always_comb begin
        next_st = st;
        next_st.vpp_sync = {st.vpp_sync[0], i_interrupt_program_voltage_pin_at_test};
        next_st.kbi_sync = {st.kbi_sync[0], i_keypad_line_zero};
        next_st.rdata_valid = 1'b0;
        reg_hit = (i_addr == `EPC_REG_ADDR); // RULE_04
        arr_hit = (i_addr >= `EPROM_FIRST) && (i_addr < `EPROM_FIRST + 16'(`EPROM_SIZE));
        // CPU writes wait until the boot decision is made, then stay out of boot mode
        cpu_wr_ok = i_wr && st.started && !st.boot_mode;
        // Counts the cycles of the current program power pulse
        next_st.plen = st.program_power ? (st.plen + 16'h0001) : 16'h0000;
        // The strap synchronisers are cleared by reset, so the boot decision
        // waits two edges for them to fill with the real pin levels
        if (!st.started) begin
            if (st.settle == 2'h2) begin
                next_st.started = 1'b1;
                next_st.boot_mode = st.vpp_sync[1] && st.kbi_sync[1]; // RULE_01
            end else begin
                next_st.settle = st.settle + 2'h1;
            end
        end
        if (cpu_wr_ok && reg_hit) begin
            next_st.latch_select = i_wdata[`EPC_LATCH_BIT]; // RULE_05
            next_st.program_power = i_wdata[`EPC_POWER_BIT] && i_wdata[`EPC_LATCH_BIT]; // RULE_09
        end
        if (cpu_wr_ok && arr_hit && st.latch_select) begin
            next_st.prog_addr = i_addr[11:0]; // RULE_05
            next_st.prog_data = i_wdata;
        end
        if (i_rd) begin
            next_st.rdata_valid = 1'b1;
            if (reg_hit) begin
                next_st.rdata = {6'h00, st.latch_select, st.program_power}; // RULE_12
            end else if (arr_hit && !st.latch_select) begin
                next_st.rdata = i_array_rdata;
            end else begin
                next_st.rdata = 8'h00;
                next_st.rdata_valid = 1'b0; // RULE_06
            end
        end
        // Bootloader: one 1 ms pulse per byte, then verify pass
        case (st.bstate)
            BOOT_IDLE: begin
                if (st.boot_mode) begin
                    next_st.bstate = BOOT_PROG;
                    next_st.baddr = 12'h000;
                    next_st.latch_select = 1'b1;
                end
            end
            BOOT_PROG: begin
                next_st.prog_addr = st.baddr; // RULE_03
                next_st.prog_data = i_boot_src_data;
                next_st.program_power = 1'b1; // RULE_08
                next_st.bcount = 16'(PULSE_CYCLES - 1);
                next_st.bstate = BOOT_WAIT;
            end
            BOOT_WAIT: begin
                if (st.bcount == 16'h0000) begin
                    next_st.program_power = 1'b0;
                    next_st.baddr = st.baddr + 12'h001;
                    if (st.baddr == 12'hFFF) begin
                        next_st.latch_select = 1'b0;
                        next_st.bstate = BOOT_VERIFY; // RULE_03
                    end else begin
                        next_st.bstate = BOOT_PROG;
                    end
                end else begin
                    next_st.bcount = st.bcount - 16'h0001;
                end
            end
            BOOT_VERIFY: begin
                next_st.prog_addr = st.baddr;
                if (st.bcount[0]) begin
                    if (i_array_rdata != i_boot_src_data) begin
                        next_st.fail = 1'b1;
                    end
                    next_st.baddr = st.baddr + 12'h001;
                    if (st.baddr == 12'hFFF) begin
                        next_st.bstate = BOOT_DONE;
                    end
                end
                next_st.bcount = {15'h0000, ~st.bcount[0]};
            end
            BOOT_DONE: begin
                next_st.bstate = BOOT_DONE;
            end
            default: begin
                next_st.bstate = BOOT_IDLE;
            end
        endcase
        if (!next_st.latch_select) begin
            next_st.program_power = 1'b0; // RULE_09
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0; // RULE_04
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_rdata_valid = st.rdata_valid;
    assign o_latch_select = st.latch_select;
    assign o_program_power = st.program_power; // RULE_08
    assign o_prog_addr = st.prog_addr;
    assign o_prog_data = st.prog_data;
    assign o_boot_mode = st.boot_mode;
    assign o_boot_active = st.boot_mode && (st.bstate != BOOT_DONE);
    assign o_boot_verify_fail = st.fail;
    assign o_boot_done = (st.bstate == BOOT_DONE);
    // Byte index into the external source; the bootloader sequencer's baddr counter drives it
    assign o_boot_src_addr = st.baddr; // RULE_02

    a_power_needs_latch: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        st.program_power |-> st.latch_select) else $error("power without latch"); // RULE_09
    a_reg_write: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (cpu_wr_ok && reg_hit) |=> (st.latch_select == $past(i_wdata[1])))
        else $error("latch write lost"); // RULE_05
    a_reg_read: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_rd && reg_hit) |=> (o_rdata[7:2] == 6'h00 && o_rdata_valid))
        else $error("reserved bits nonzero"); // RULE_12
    a_latched_read: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_rd && arr_hit && st.latch_select) |=> !o_rdata_valid)
        else $error("read valid in programming"); // RULE_06
    a_capture_addr: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (cpu_wr_ok && arr_hit && st.latch_select) |=> (o_prog_addr == $past(i_addr[11:0])))
        else $error("address not captured"); // RULE_05
    a_power_on: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (cpu_wr_ok && reg_hit && (i_wdata[1:0] == 2'b11)) |=> o_program_power)
        else $error("power not applied"); // RULE_08
    a_boot_entry: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (!st.started && (st.settle == 2'h2) && st.vpp_sync[1] && st.kbi_sync[1])
        |=> o_boot_mode)
        else $error("boot mode missed"); // RULE_01
    a_boot_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (st.bstate == BOOT_PROG) |=> o_program_power [*2])
        else $error("boot pulse too short"); // RULE_03
    // Each boot pulse lasts exactly the configured number of cycles
    a_boot_pulse_len: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (st.boot_mode && st.program_power && !next_st.program_power)
        |-> (st.plen == 16'(PULSE_CYCLES - 1)))
        else $error("boot pulse length wrong"); // RULE_03
    a_verify_unpowered: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (st.bstate == BOOT_VERIFY) |-> (!st.latch_select && !st.program_power))
        else $error("verify pass while programming"); // RULE_03
    c_boot: cover property (@(posedge i_sys_clk) st.bstate == BOOT_VERIFY);
    c_cpu_prog: cover property (@(posedge i_sys_clk) o_program_power && !st.boot_mode);
    c_reg_read: cover property (@(posedge i_sys_clk) i_rd && reg_hit);
    c_boot_done: cover property (@(posedge i_sys_clk) o_boot_done && !o_boot_verify_fail);
endmodule
`default_nettype wire

// ===== testbench/eprom_program_control_tb.sv
// Self-checking bench for the EPROM program control block
`include "eprom_prog_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module eprom_program_control_tb;
    import eprom_prog_pkg::*;
    localparam int unsigned PULSE = 4;
    logic clk, arst_n, wr, rd, vpin, kline, rvalid, boot_mode, boot_active, vfail, done;
    logic latch, power, pprev;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, pdata, ardata, src_data, d, got;
    logic [11:0] src_addr, paddr, a;
    logic [7:0] mem [4096];
    logic [31:0] seed;
    logic v;
    int fail_count, checked, rises, n;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] src_byte(input logic [11:0] x);
        return x[7:0] ^ {x[11:8], x[11:8]} ^ 8'h5A;
    endfunction
    assign src_data = src_byte(src_addr);
    // Array reads follow the CPU address, or the latched address while booting
    assign ardata = mem[boot_active ? paddr : addr[11:0]];
    eprom_program_control #(.PULSE_CYCLES(PULSE)) eprom_program_control_i (
        .i_sys_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_rdata_valid(rvalid),
        .i_interrupt_program_voltage_pin_at_test(vpin), .i_keypad_line_zero(kline),
        .i_boot_src_data(src_data), .o_boot_src_addr(src_addr), .o_boot_mode(boot_mode),
        .o_boot_active(boot_active), .o_boot_verify_fail(vfail), .o_boot_done(done),
        .o_latch_select(latch), .o_program_power(power), .o_prog_addr(paddr),
        .o_prog_data(pdata), .i_array_rdata(ardata));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Powered array cells take the latched byte; rising power edges are counted
    always @(posedge clk) begin
        if (arst_n !== 1'b1) begin
            rises <= 0;
            for (int i = 0; i < 4096; i++) mem[i] <= 8'hFF;
        end else begin
            if (power === 1'b1) mem[paddr] <= pdata;
            if (power === 1'b1 && pprev !== 1'b1) rises <= rises + 1;
        end
        pprev <= power;
    end
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] seen);
        checked++;
        if (exp !== seen) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_bus(input logic [15:0] ad, input logic [7:0] dt);
        @(posedge clk);
        #5 addr = ad; wdata = dt; wr = 1'b1;
        @(posedge clk);
        #5 wr = 1'b0;
    endtask
    task automatic rd_bus(input logic [15:0] ad, output logic vo, output logic [7:0] dout);
        @(posedge clk);
        #5 addr = ad; rd = 1'b1;
        @(posedge clk);
        #5 vo = rvalid; dout = rdata; rd = 1'b0;
    endtask
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        fail_count = 0; checked = 0;
        arst_n = 1'b0; wr = 1'b0; rd = 1'b0; vpin = 1'b0; kline = 1'b0;
        addr = 16'h0000; wdata = 8'h00; seed = 32'h3EDC533A;
        repeat (8) @(posedge clk);
        #5 arst_n = 1'b1;
        repeat (2) @(posedge clk);
        rd_bus(`EPC_REG_ADDR, v, got);
        chk("reg reset", 12'h100, {3'h0, v, got});
        wr_bus(`EPC_REG_ADDR, 8'h01);
        chk("power no latch", 12'h000, {11'h0, power});
        wr_bus(`EPC_REG_ADDR, 8'hFE);
        rd_bus(`EPC_REG_ADDR, v, got);
        chk("reserved bits", 12'h102, {3'h0, v, got});
        vpin = 1'b1;
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            a = (i == 0) ? 12'hFFF : seed[11:0];
            d = seed[23:16];
            wr_bus(`EPC_REG_ADDR, 8'h02);
            wr_bus({4'h1, a}, d);
            chk("latched addr", a, paddr);
            chk("latched data", {4'h0, d}, {4'h0, pdata});
            rd_bus({4'h1, a}, v, got);
            chk("read in latch", 12'h000, {11'h0, v});
            wr_bus(`EPC_REG_ADDR, 8'h03);
            chk("power on", 12'h003, {10'h0, latch, power});
            repeat (PULSE) @(posedge clk);
            wr_bus(`EPC_REG_ADDR, 8'h02);
            chk("power off", 12'h002, {10'h0, latch, power});
            wr_bus(`EPC_REG_ADDR, 8'h00);
            chk("unlatched", 12'h000, {10'h0, latch, power});
            rd_bus({4'h1, a}, v, got);
            chk("normal read", {3'h0, 1'b1, d}, {3'h0, v, got});
        end
        rd_bus(16'h0080, v, got);
        chk("unmapped read", 12'h000, {11'h0, v});
        #5 arst_n = 1'b0; vpin = 1'b1; kline = 1'b1;
        repeat (3) @(posedge clk);
        #5 arst_n = 1'b1;
        repeat (3) @(posedge clk);
        #5;
        chk("boot entry", 12'h001, {11'h0, boot_mode});
        n = 0;
        while (done !== 1'b1 && n < 40000) begin
            @(posedge clk);
            #5;
            n++;
        end
        if (n >= 40000) begin
            fail_count++;
            $display("CHECK FAILED boot done expected 1 seen %b", done);
        end else begin
            chk("byte pulses", 12'h001, rises[23:12]);
            chk("byte pulses low", 12'h000, rises[11:0]);
            chk("verify pass", 12'h000, {11'h0, vfail});
            chk("boot finished", 12'h000, {11'h0, boot_active});
            for (int i = 0; i < 4096; i += 97) chk("array byte", {4'h0, src_byte(i[11:0])},
                {4'h0, mem[i]});
        end
        close_out();
    end
endmodule
`default_nettype wire
